// >>> hw/lct_pkg.sv
package lct_pkg;
    typedef enum logic [1:0] {
        LCT_MODE_13 = 2'h0,
        LCT_MODE_16 = 2'h1,
        LCT_MODE_RELOAD = 2'h2,
        LCT_MODE_SPLIT = 2'h3
    } lct_mode_t;

    localparam logic [7:0] OFS_A_LOW = 8'h00;
    localparam logic [7:0] OFS_A_HIGH = 8'h04;
    localparam logic [7:0] OFS_B_LOW = 8'h08;
    localparam logic [7:0] OFS_B_HIGH = 8'h0c;
    localparam logic [7:0] OFS_CTL = 8'h10;
    localparam logic [7:0] OFS_MODE = 8'h14;
    localparam logic [7:0] OFS_CLK = 8'h18;
    localparam logic [7:0] OFS_GATE_CFG = 8'h1c;
    localparam logic [7:0] OFS_IEN = 8'h20;
    localparam logic [7:0] OFS_IST = 8'h24;
    localparam logic [7:0] OFS_IMASK = 8'h28;
    localparam logic [7:0] OFS_CH_STEP = 8'h08;

    localparam int CTL_RUN_A = 4;
    localparam int CTL_TF_A = 5;
    localparam int CTL_CH_STEP = 2;
    localparam logic [7:0] CTL_WR_MASK = 8'hf0;
    localparam int MODE_CH_STEP = 4;
    localparam int MODE_CT_OFS = 2;
    localparam int MODE_GATE_OFS = 3;
    localparam int CLK_SCALE_LSB = 0;
    localparam int CLK_SYS_A = 3;
    localparam logic [7:0] CLK_WR_MASK = 8'h1b;

    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [1:0] RST_PAIR = 2'h0;

    localparam int PRE_W = 6;
    localparam logic [5:0] PRE_DIV_0 = 6'h0c;
    localparam logic [5:0] PRE_DIV_1 = 6'h04;
    localparam logic [5:0] PRE_DIV_2 = 6'h30;
    localparam logic [5:0] PRE_DIV_3 = 6'h08;
endpackage : lct_pkg

// >>> hw/lct_chan.sv
`timescale 1ns/1ps
module lct_chan (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic tick_i,
    input wire logic [1:0] mode_i,
    input wire logic wr_low_i,
    input wire logic wr_high_i,
    input wire logic [7:0] wdat_i,
    output logic [7:0] low_o,
    output logic [7:0] high_o,
    output logic ovf_o
);
    logic [7:0] next_low;
    logic [7:0] next_high;
    logic next_ovf;
    logic [12:0] sum13;
    logic [15:0] sum16;

    always_comb begin
        next_low = low_o;
        next_high = high_o;
        next_ovf = 1'b0;
        sum13 = {high_o, low_o[4:0]} + 13'h0001;
        sum16 = {high_o, low_o} + 16'h0001;
        if (tick_i) begin
            case (mode_i)
                lct_pkg::LCT_MODE_13: begin
                    next_high = sum13[12:5];
                    next_low = {low_o[7:5], sum13[4:0]};
                    next_ovf = (sum13 == 13'h0000);
                end
                lct_pkg::LCT_MODE_16: begin
                    next_high = sum16[15:8];
                    next_low = sum16[7:0];
                    next_ovf = (sum16 == 16'h0000);
                end
                lct_pkg::LCT_MODE_RELOAD: begin
                    if (low_o == 8'hff) begin
                        next_low = high_o;
                        next_ovf = 1'b1;
                    end else begin
                        next_low = low_o + 8'h01;
                    end
                end
                default: begin
                    // Split mode is not provided; the timer simply holds
                    next_low = low_o;
                end
            endcase
        end
        // A software write wins over a count in the same cycle
        if (wr_low_i) begin
            next_low = wdat_i;
        end
        if (wr_high_i) begin
            next_high = wdat_i;
        end
    end

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            low_o <= lct_pkg::RST_BYTE;
            high_o <= lct_pkg::RST_BYTE;
            ovf_o <= 1'b0;
        end else begin
            low_o <= next_low;
            high_o <= next_high;
            ovf_o <= next_ovf;
        end
    end

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);

    roll_13_a: assert property (tick_i && mode_i == lct_pkg::LCT_MODE_13 && !wr_low_i
        && !wr_high_i && {high_o, low_o[4:0]} == 13'h1fff
        |=> ovf_o && high_o == 8'h00 && low_o[4:0] == 5'h00)
        else $error("13-bit rollover did not flag");
    inc_16_a: assert property (tick_i && mode_i == lct_pkg::LCT_MODE_16 && !wr_low_i
        && !wr_high_i |=> {high_o, low_o} == $past({high_o, low_o}) + 16'h0001
        && ovf_o == ({high_o, low_o} == 16'h0000))
        else $error("16-bit count step wrong");
    reload_8_a: assert property (tick_i && mode_i == lct_pkg::LCT_MODE_RELOAD
        && low_o == 8'hff && !wr_low_i && !wr_high_i
        |=> ovf_o && low_o == $past(high_o) && $stable(high_o))
        else $error("reload mode did not reload");
    hold_idle_a: assert property (!tick_i && !wr_low_i && !wr_high_i
        |=> $stable(low_o) && $stable(high_o) && !ovf_o)
        else $error("count moved without a tick");
endmodule : lct_chan

// >>> hw/lct_top.sv
// Implementation choices: the address map and the Wishbone register port.
`timescale 1ns/1ps
module lct_top #(
    parameter int ADR_W = 8
) (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [ADR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic wb_ack_o,
    output logic [31:0] wb_dat_o,
    input wire logic event_pin_a_i,
    input wire logic event_pin_b_i,
    input wire logic gate_input_a_i,
    input wire logic gate_input_b_i,
    input wire logic irq_ack_a_i,
    input wire logic irq_ack_b_i,
    output logic timer_a_irq_o,
    output logic timer_b_irq_o,
    output logic irq_o
);
    if (ADR_W < 8) begin : g_adr_check
        $error("ADR_W must cover the 8-bit register map");
    end

    function automatic logic hit(input logic [ADR_W-1:0] a, input logic [7:0] ofs);
        logic [ADR_W-1:0] o;
        o = ADR_W'(ofs);
        return a[ADR_W-1:2] == o[ADR_W-1:2];
    endfunction : hit

    function automatic logic [5:0] pre_div(input int k);
        case (k)
            0: return lct_pkg::PRE_DIV_0;
            1: return lct_pkg::PRE_DIV_1;
            2: return lct_pkg::PRE_DIV_2;
            default: return lct_pkg::PRE_DIV_3;
        endcase
    endfunction : pre_div

    // Register state
    logic [7:0] ctl;
    logic [7:0] mode_sel;
    logic [7:0] clk_ctl;
    logic [1:0] gate_cfg;
    logic [1:0] ien;
    logic [1:0] ist;
    logic [1:0] imask;
    logic [7:0] next_ctl;
    logic [7:0] next_mode_sel;
    logic [7:0] next_clk_ctl;
    logic [1:0] next_gate_cfg;
    logic [1:0] next_ien;
    logic [1:0] next_ist;
    logic [1:0] next_imask;
    logic next_ack;
    logic [31:0] next_dat;
    logic next_irq;
    logic next_tirq_a;
    logic next_tirq_b;

    // Per-timer views
    logic [1:0] ovf;
    logic [1:0] tick;
    logic [1:0] run;
    logic [1:0] tf;
    logic [1:0] gate_in;
    logic [1:0] irq_ack;
    logic [1:0] wr_low;
    logic [1:0] wr_high;
    logic [7:0] low [2];
    logic [7:0] high [2];

    // Bus decode
    logic acc;
    logic wr;
    logic rd;
    logic [7:0] wbyte;
    logic [7:0] rbyte;

    // Edge detect on event pins: sample then delay, fall seen one cycle late
    logic [1:0] ev_s;
    logic [1:0] ev_d;
    logic [1:0] next_ev_s;
    logic [1:0] next_ev_d;
    logic [1:0] fall;

    // Prescaler
    logic [5:0] pre_cnt [4];
    logic [3:0] pre_tick;

    assign gate_in = {gate_input_b_i, gate_input_a_i};
    assign irq_ack = {irq_ack_b_i, irq_ack_a_i};
    assign acc = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wr = acc && wb_we_i && wb_sel_i[0];
    assign rd = acc && !wb_we_i;
    assign wbyte = wb_dat_i[7:0];

    always_comb begin
        next_ev_s = {event_pin_b_i, event_pin_a_i};
        next_ev_d = ev_s;
    end

    assign fall = ev_d & ~ev_s;

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            ev_s <= 2'h3;
            ev_d <= 2'h3;
        end else begin
            ev_s <= next_ev_s;
            ev_d <= next_ev_d;
        end
    end

    // Free-running dividers; each gives a one-cycle enable per period
    for (genvar k = 0; k < 4; k++) begin : g_pre
        logic [5:0] next_pre;
        always_comb begin
            next_pre = (pre_cnt[k] == pre_div(k) - 6'h01) ? 6'h00 : pre_cnt[k] + 6'h01;
        end
        assign pre_tick[k] = (pre_cnt[k] == pre_div(k) - 6'h01);
        always_ff @(posedge clk_sys_i or posedge rst_i) begin
            if (rst_i) begin
                pre_cnt[k] <= 6'h00;
            end else begin
                pre_cnt[k] <= next_pre;
            end
        end
    end

    for (genvar i = 0; i < 2; i++) begin : g_ch
        localparam int RB = lct_pkg::CTL_RUN_A + i * lct_pkg::CTL_CH_STEP;
        localparam int FB = lct_pkg::CTL_TF_A + i * lct_pkg::CTL_CH_STEP;
        localparam int MB = i * lct_pkg::MODE_CH_STEP;
        logic ct_sel;
        logic gate_en;
        logic sys_sel;
        logic gate_ok;
        logic src;
        assign run[i] = ctl[RB];
        assign tf[i] = ctl[FB];
        assign ct_sel = mode_sel[MB + lct_pkg::MODE_CT_OFS];
        assign gate_en = mode_sel[MB + lct_pkg::MODE_GATE_OFS];
        assign sys_sel = clk_ctl[lct_pkg::CLK_SYS_A + i];
        // Gate polarity bit set means the gate input is active high
        assign gate_ok = !gate_en || (gate_in[i] == gate_cfg[i]);
        assign src = ct_sel ? fall[i]
            : (sys_sel ? 1'b1 : pre_tick[clk_ctl[lct_pkg::CLK_SCALE_LSB +: 2]]);
        assign tick[i] = run[i] && gate_ok && src;
        assign wr_low[i] = wr && hit(wb_adr_i, 8'(lct_pkg::OFS_A_LOW
            + lct_pkg::OFS_CH_STEP * i));
        assign wr_high[i] = wr && hit(wb_adr_i, 8'(lct_pkg::OFS_A_HIGH
            + lct_pkg::OFS_CH_STEP * i));

        lct_chan u_chan (
            .clk_sys_i(clk_sys_i),
            .rst_i(rst_i),
            .tick_i(tick[i]),
            .mode_i(mode_sel[MB +: 2]),
            .wr_low_i(wr_low[i]),
            .wr_high_i(wr_high[i]),
            .wdat_i(wbyte),
            .low_o(low[i]),
            .high_o(high[i]),
            .ovf_o(ovf[i])
        );

        counter_edge_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
            run[i] && gate_ok && ct_sel && $fell(ev_s[i]) |-> tick[i])
            else $error("event edge not counted");
        gate_block_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
            (!run[i] || (gate_en && gate_in[i] != gate_cfg[i])) && !wr_low[i] && !wr_high[i]
            |=> $stable(low[i]) && $stable(high[i]))
            else $error("timer counted while stopped or gated");
        sys_rate_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
            run[i] && !gate_en && !ct_sel && sys_sel |-> tick[i])
            else $error("system clock source missed a cycle");
        flag_set_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
            ovf[i] |=> tf[i])
            else $error("overflow did not set the flag");
        flag_hold_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
            tf[i] && !irq_ack[i] && !(wr && hit(wb_adr_i, lct_pkg::OFS_CTL))
            |=> tf[i])
            else $error("flag cleared without cause");
        ovf_cov: cover property (@(posedge clk_sys_i) disable iff (rst_i)
            ovf[i] ##1 tf[i]);
    end

    always_comb begin
        rbyte = 8'h00;
        if (hit(wb_adr_i, lct_pkg::OFS_A_LOW)) begin
            rbyte = low[0];
        end else if (hit(wb_adr_i, lct_pkg::OFS_A_HIGH)) begin
            rbyte = high[0];
        end else if (hit(wb_adr_i, lct_pkg::OFS_B_LOW)) begin
            rbyte = low[1];
        end else if (hit(wb_adr_i, lct_pkg::OFS_B_HIGH)) begin
            rbyte = high[1];
        end else if (hit(wb_adr_i, lct_pkg::OFS_CTL)) begin
            rbyte = ctl;
        end else if (hit(wb_adr_i, lct_pkg::OFS_MODE)) begin
            rbyte = mode_sel;
        end else if (hit(wb_adr_i, lct_pkg::OFS_CLK)) begin
            rbyte = clk_ctl;
        end else if (hit(wb_adr_i, lct_pkg::OFS_GATE_CFG)) begin
            rbyte = {6'h00, gate_cfg};
        end else if (hit(wb_adr_i, lct_pkg::OFS_IEN)) begin
            rbyte = {6'h00, ien};
        end else if (hit(wb_adr_i, lct_pkg::OFS_IST)) begin
            rbyte = {6'h00, ist};
        end else if (hit(wb_adr_i, lct_pkg::OFS_IMASK)) begin
            rbyte = {6'h00, imask};
        end
    end

    always_comb begin
        next_ack = acc;
        next_dat = rd ? {24'h000000, rbyte} : 32'h00000000;
        next_ctl = ctl;
        next_mode_sel = mode_sel;
        next_clk_ctl = clk_ctl;
        next_gate_cfg = gate_cfg;
        next_ien = ien;
        next_imask = imask;
        // Run and flag bits only; a run write leaves the count alone
        if (wr && hit(wb_adr_i, lct_pkg::OFS_CTL)) begin
            next_ctl = wbyte & lct_pkg::CTL_WR_MASK;
        end
        if (wr && hit(wb_adr_i, lct_pkg::OFS_MODE)) begin
            next_mode_sel = wbyte;
        end
        if (wr && hit(wb_adr_i, lct_pkg::OFS_CLK)) begin
            next_clk_ctl = wbyte & lct_pkg::CLK_WR_MASK;
        end
        if (wr && hit(wb_adr_i, lct_pkg::OFS_GATE_CFG)) begin
            next_gate_cfg = wbyte[1:0];
        end
        if (wr && hit(wb_adr_i, lct_pkg::OFS_IEN)) begin
            next_ien = wbyte[1:0];
        end
        if (wr && hit(wb_adr_i, lct_pkg::OFS_IMASK)) begin
            next_imask = wbyte[1:0];
        end
        // Overflow beats a same-cycle clear so no event is lost
        for (int i = 0; i < 2; i++) begin
            next_ctl[lct_pkg::CTL_TF_A + i * lct_pkg::CTL_CH_STEP] = ovf[i]
                || (next_ctl[lct_pkg::CTL_TF_A + i * lct_pkg::CTL_CH_STEP]
                && !irq_ack[i]);
        end
        // Status clears on read, again losing nothing that lands that cycle
        next_ist = ovf | ((rd && hit(wb_adr_i, lct_pkg::OFS_IST)) ? 2'h0 : ist);
        next_irq = |(next_ist & next_imask);
        next_tirq_a = next_ctl[lct_pkg::CTL_TF_A] && next_ien[0];
        next_tirq_b = next_ctl[lct_pkg::CTL_TF_A + lct_pkg::CTL_CH_STEP]
            && next_ien[1];
    end

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
            ctl <= lct_pkg::RST_BYTE;
            mode_sel <= lct_pkg::RST_BYTE;
            clk_ctl <= lct_pkg::RST_BYTE;
            gate_cfg <= lct_pkg::RST_PAIR;
            ien <= lct_pkg::RST_PAIR;
            ist <= lct_pkg::RST_PAIR;
            imask <= lct_pkg::RST_PAIR;
            irq_o <= 1'b0;
            timer_a_irq_o <= 1'b0;
            timer_b_irq_o <= 1'b0;
        end else begin
            wb_ack_o <= next_ack;
            wb_dat_o <= next_dat;
            ctl <= next_ctl;
            mode_sel <= next_mode_sel;
            clk_ctl <= next_clk_ctl;
            gate_cfg <= next_gate_cfg;
            ien <= next_ien;
            ist <= next_ist;
            imask <= next_imask;
            irq_o <= next_irq;
            timer_a_irq_o <= next_tirq_a;
            timer_b_irq_o <= next_tirq_b;
        end
    end

    bus_ack_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
        else $error("bus answer not given in one cycle");
    irq_tie_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        timer_a_irq_o == (tf[0] && ien[0]) && timer_b_irq_o == (tf[1] && ien[1]))
        else $error("timer request does not follow flag and enable");
    run_keep_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        $rose(run[0]) && !$past(tick[0]) && !$past(wr_low[0]) |-> $stable(low[0]))
        else $error("starting the timer changed its count");
    irq_cov: cover property (@(posedge clk_sys_i) disable iff (rst_i) $rose(irq_o));
    reload_cov: cover property (@(posedge clk_sys_i) disable iff (rst_i)
        ovf[0] && mode_sel[1:0] == lct_pkg::LCT_MODE_RELOAD);
endmodule : lct_top

// >>> dv/lct_pins_model.sv
`timescale 1ns/1ps
module lct_pins_model (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic pulse_a_i,
    input wire logic pulse_b_i,
    input wire logic gate_a_lvl_i,
    input wire logic gate_b_lvl_i,
    output logic event_pin_a_o,
    output logic event_pin_b_o,
    output logic gate_a_o,
    output logic gate_b_o
);
    logic [2:0] cnt_a;
    logic [2:0] cnt_b;
    // Six-cycle frame: three low then three high, well under a quarter clock
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            cnt_a <= 3'h0;
            cnt_b <= 3'h0;
        end else begin
            cnt_a <= (cnt_a != 3'h0) ? cnt_a - 3'h1 : (pulse_a_i ? 3'h6 : 3'h0);
            cnt_b <= (cnt_b != 3'h0) ? cnt_b - 3'h1 : (pulse_b_i ? 3'h6 : 3'h0);
        end
    end
    assign event_pin_a_o = !(cnt_a > 3'h3);
    assign event_pin_b_o = !(cnt_b > 3'h3);
    assign gate_a_o = gate_a_lvl_i;
    assign gate_b_o = gate_b_lvl_i;
endmodule : lct_pins_model

// >>> dv/lct_top_tb.sv
`timescale 1ns/1ps
module lct_top_tb;
    logic clk_sys_i, rst_i, cyc, stb, we, ack_a, ack_b, pa, pb, gla, glb;
    logic [7:0] adr;
    logic [31:0] dwr, q;
    logic [3:0] sel;
    logic ack, ev_a, ev_b, g_a, g_b, irq_a, irq_b, irq;
    logic [31:0] dat;
    int error_cnt, checks_done;

    lct_top dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dwr), .wb_ack_o(ack),
        .wb_dat_o(dat), .event_pin_a_i(ev_a), .event_pin_b_i(ev_b), .gate_input_a_i(g_a),
        .gate_input_b_i(g_b), .irq_ack_a_i(ack_a), .irq_ack_b_i(ack_b),
        .timer_a_irq_o(irq_a), .timer_b_irq_o(irq_b), .irq_o(irq));
    lct_pins_model pins (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .pulse_a_i(pa),
        .pulse_b_i(pb), .gate_a_lvl_i(gla), .gate_b_lvl_i(glb), .event_pin_a_o(ev_a),
        .event_pin_b_o(ev_b), .gate_a_o(g_a), .gate_b_o(g_b));

    initial begin
        clk_sys_i = 1'b0;
        forever #50 clk_sys_i = ~clk_sys_i;
    end

    task automatic close_out;
        $display("checks %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : close_out

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD %0t got %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
        int i;
        @(posedge clk_sys_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dwr <= {24'h0, d};
        i = 0;
        do begin
            @(posedge clk_sys_i);
            i++;
        end while (ack !== 1'b1 && i < 20);
        q = dat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        if (ack !== 1'b1) begin
            error_cnt++;
            $display("BAD %0t bus answer missing", $time);
            close_out();
        end
    endtask : wb

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        wb(1'b1, a, d);
    endtask : wr

    task automatic rd(input logic [7:0] a);
        wb(1'b0, a, 8'h00);
    endtask : rd

    // Waits for a timer interrupt; the load is always done before run is set
    task automatic run_to_irq(input logic [7:0] mode, input logic [7:0] hi, input logic [7:0] lo);
        int i;
        logic seen;
        wr(8'h14, mode);
        wr(8'h04, hi);
        wr(8'h00, lo);
        wr(8'h10, 8'h10);
        i = 0;
        while (irq_a !== 1'b1 && i < 50) begin
            @(posedge clk_sys_i);
            i++;
        end
        seen = irq_a;
        chk(seen, 1'b1);
        wr(8'h10, 8'h00);
        if (seen !== 1'b1) close_out();
    endtask : run_to_irq

    task automatic t_regs;
        rd(8'h10); chk(q, 32'h0);
        rd(8'h2c); chk(q, 32'h0);
        wr(8'h10, 8'h0f);
        rd(8'h10); chk(q, 32'h0);
        wr(8'h28, 8'h03);
        rd(8'h28); chk(q, 32'h3);
        // A write without its low byte lane must leave the register alone
        sel <= 4'h0;
        wr(8'h28, 8'h00);
        sel <= 4'h1;
        rd(8'h28); chk(q, 32'h3);
        $display("test regs done");
    endtask : t_regs

    task automatic t_ovf16;
        wr(8'h20, 8'h01);
        wr(8'h18, 8'h08);
        run_to_irq(8'h01, 8'hff, 8'hff);
        chk(irq, 1'b1);
        rd(8'h04); chk(q, 32'h0);
        rd(8'h00); chk(q > 32'h0 && q < 32'h20, 1'b1);
        rd(8'h24); chk(q, 32'h1);
        rd(8'h24); chk(q, 32'h0);
        @(posedge clk_sys_i);
        chk(irq, 1'b0);
        $display("test sixteen done");
    endtask : t_ovf16

    task automatic t_ovf13;
        run_to_irq(8'h00, 8'hff, 8'hff);
        rd(8'h04); chk(q, 32'h0);
        rd(8'h00); chk(q[4:0] != 5'h0 && q[4:0] < 5'h10, 1'b1);
        $display("test thirteen done");
    endtask : t_ovf13

    task automatic t_reload;
        run_to_irq(8'h02, 8'hf0, 8'hfe);
        rd(8'h04); chk(q, 32'hf0);
        rd(8'h00); chk(q[7:4], 4'hf);
        $display("test reload done");
    endtask : t_reload

    task automatic pulse(input logic b, input int n);
        repeat (n) begin
            @(posedge clk_sys_i);
            if (b) pb <= 1'b1;
            else pa <= 1'b1;
            @(posedge clk_sys_i);
            pa <= 1'b0;
            pb <= 1'b0;
            repeat (8) @(posedge clk_sys_i);
        end
    endtask : pulse

    task automatic t_events;
        wr(8'h00, 8'h00);
        wr(8'h04, 8'h00);
        wr(8'h08, 8'h00);
        wr(8'h0c, 8'h00);
        wr(8'h14, 8'h5d);
        wr(8'h1c, 8'h00);
        wr(8'h10, 8'h50);
        pulse(1'b0, 3);
        pulse(1'b1, 5);
        rd(8'h00); chk(q, 32'h3);
        rd(8'h08); chk(q, 32'h5);
        gla <= 1'b1;
        pulse(1'b0, 2);
        rd(8'h00); chk(q, 32'h3);
        wr(8'h14, 8'hdd);
        wr(8'h1c, 8'h02);
        pulse(1'b1, 2);
        rd(8'h08); chk(q, 32'h5);
        glb <= 1'b1;
        pulse(1'b1, 2);
        rd(8'h08); chk(q, 32'h7);
        wr(8'h10, 8'h00);
        $display("test events done");
    endtask : t_events

    task automatic t_clocks;
        logic [7:0] sc [5] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h08};
        int dv [5] = '{12, 4, 48, 8, 1};
        wr(8'h14, 8'h01);
        for (int k = 0; k < 5; k++) begin
            wr(8'h18, sc[k]);
            wr(8'h00, 8'h00);
            wr(8'h10, 8'h10);
            repeat (96) @(posedge clk_sys_i);
            wr(8'h10, 8'h00);
            rd(8'h00);
            chk(q + 1 >= 99 / dv[k] && q <= 99 / dv[k] + 1, 1'b1);
        end
        // The unused fourth mode must hold the count even with ticks arriving
        wr(8'h14, 8'h03);
        wr(8'h00, 8'h05);
        wr(8'h10, 8'h10);
        repeat (8) @(posedge clk_sys_i);
        wr(8'h10, 8'h00);
        rd(8'h00); chk(q, 32'h5);
        $display("test clocks done");
    endtask : t_clocks

    task automatic t_ack;
        wr(8'h20, 8'h00);
        wr(8'h10, 8'ha0);
        repeat (3) @(posedge clk_sys_i);
        chk({irq_a, irq_b}, 2'b00);
        wr(8'h20, 8'h03);
        repeat (3) @(posedge clk_sys_i);
        chk({irq_a, irq_b}, 2'b11);
        ack_a <= 1'b1;
        ack_b <= 1'b1;
        @(posedge clk_sys_i);
        ack_a <= 1'b0;
        ack_b <= 1'b0;
        rd(8'h10); chk(q, 32'h0);
        $display("test vector done");
    endtask : t_ack

    initial begin
        repeat (100000) @(posedge clk_sys_i);
        error_cnt++;
        $display("BAD %0t run limit reached", $time);
        close_out();
    end

    initial begin
        {rst_i, cyc, stb, we, ack_a, ack_b, pa, pb, gla, glb} = 10'b1000000000;
        adr = 8'h00;
        dwr = 32'h0;
        sel = 4'h1;
        error_cnt = 0;
        checks_done = 0;
        repeat (4) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        t_regs();
        t_ovf16();
        t_ovf13();
        t_reload();
        t_events();
        t_clocks();
        t_ack();
        close_out();
    end
endmodule : lct_top_tb
